// ### core/psc_fault_flags.sv
`timescale 1ns/1ps
module psc_fault_flags
  import psc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [psc_pkg::PSC_FLT_W-1:0] fault_evt,
  input wire logic [psc_pkg::PSC_FLT_W-1:0] fault_mask,
  input wire logic clr_we,
  input wire logic [psc_pkg::PSC_FLT_W-1:0] clr_bits,
  output logic [psc_pkg::PSC_FLT_W-1:0] flags_q,
  output logic fault_alert_n
);
  import psc_pkg::*;

  logic [PSC_FLT_W-1:0] flags_d;
  logic alert_n_q;

  // sticky flags: write one to clear, a new event in the same cycle wins
  always_comb begin
    flags_d = flags_q;
    if (clr_we) begin
      flags_d = flags_d & ~clr_bits;
    end
    flags_d = flags_d | fault_evt;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  // alert is loaded from the same next value, so it falls in the flag's cycle
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      alert_n_q <= 1'b1;
    end else begin
      alert_n_q <= ~|(flags_d & fault_mask);
    end
  end

  assign fault_alert_n = alert_n_q;

  a_alert_with_flag: assert property (@(posedge core_clk) disable iff (!rstn)
    fault_alert_n == ~|(flags_q & $past(fault_mask)))
    else $error("alert does not follow flag set");
  a_flag_set_wins: assert property (@(posedge core_clk) disable iff (!rstn)
    |fault_evt |=> ((flags_q & $past(fault_evt)) == $past(fault_evt)))
    else $error("fault event lost");
endmodule

// ### core/psc_pins.sv
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// - alert asserts in the same cycle that any enabled fault flag is set.
// - management clock and data lines are open-drain, driven low only.
// - kill input idles high; main output needs it low, drops when it rises.
// - remote on input idles high; low turns main on, open turns off.
// - a strap shorted to return reads low, open or pulled up reads high.
// - target address is strap 2, 1, 0 with strap 2 most significant.
// - alert output is low while a fault is flagged, high otherwise; here a flag pulls it low only while its mask bit is set.
// - power good only while outputs valid, main enabled and no fault.
// - power good negates within 2 ms after remote on is released.
module psc_pins
  import psc_pkg::*;
#(
  parameter int unsigned PG_OFF_CYCLES = psc_pkg::PSC_PG_OFF_CYCLES
)
(
  input wire logic core_clk,
  input wire logic rstn,
  // axi4-lite register port
  input wire logic [psc_pkg::PSC_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [psc_pkg::PSC_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // control and status pins
  input wire logic hot_swap_kill_n,
  input wire logic remote_on_n,
  input wire logic addr_strap_2,
  input wire logic addr_strap_1,
  input wire logic addr_strap_0,
  input wire logic outputs_valid,
  input wire logic [psc_pkg::PSC_FLT_W-1:0] fault_evt,
  output logic main_enable,
  output logic power_good,
  output logic fault_alert_n,
  output logic present_n,
  output logic [2:0] target_addr,
  // management serial lines, open drain
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  input wire logic mgmt_scl_low,
  input wire logic mgmt_sda_low,
  output logic mgmt_scl,
  output logic mgmt_sda
);
  import psc_pkg::*;

  logic ctrl_en_q;
  logic [PSC_FLT_W-1:0] mask_q;
  logic [PSC_FLT_W-1:0] flags_q;
  logic [2:0] addr_q;
  logic strap_taken_q;
  logic main_en_q;
  logic pg_q;
  logic aw_have_q;
  logic w_have_q;
  logic [PSC_ADDR_W-1:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic wr_fire;
  logic [PSC_ADDR_W-1:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic clr_we;
  logic on_req;

  // true when the offset names one of our four words
  function automatic logic ofs_mapped(input logic [PSC_ADDR_W-1:0] a);
    ofs_mapped = (a == PSC_CTRL_OFS) || (a == PSC_STATUS_OFS) ||
                 (a == PSC_FAULT_OFS) || (a == PSC_MASK_OFS);
  endfunction

  // axi4-lite write side
  // address and data are taken in either order; one write in flight
  assign s_axi_awready = !aw_have_q && !bvalid_q;
  assign s_axi_wready = !w_have_q && !bvalid_q;
  assign wr_addr = aw_have_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_have_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_have_q ? wstrb_q : s_axi_wstrb;
  assign wr_fire = !bvalid_q && (aw_have_q || s_axi_awvalid) && (w_have_q || s_axi_wvalid);

  // hold halves that arrived alone
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wr_fire) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
    end
  end

  // write response, held until the master takes it
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      bvalid_q <= 1'b0;
      bresp_q <= PSC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= ofs_mapped(wr_addr) ? PSC_RESP_OKAY : PSC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  // control and mask words; only byte lane 0 carries bits
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ctrl_en_q <= PSC_CTRL_RST;
      mask_q <= PSC_MASK_RST;
    end else if (wr_fire && wr_strb[0]) begin
      if (wr_addr == PSC_CTRL_OFS) begin
        ctrl_en_q <= wr_data[0];
      end
      if (wr_addr == PSC_MASK_OFS) begin
        mask_q <= wr_data[PSC_FLT_W-1:0];
      end
    end
  end

  assign clr_we = wr_fire && wr_strb[0] && (wr_addr == PSC_FAULT_OFS);

  // axi4-lite read side
  assign s_axi_arready = !rvalid_q;

  // read data is registered; status reflects live pin state
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= PSC_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= '0;
      rresp_q <= PSC_RESP_OKAY;
      case (s_axi_araddr)
        PSC_CTRL_OFS: begin
          rdata_q[0] <= ctrl_en_q;
        end
        PSC_STATUS_OFS: begin
          rdata_q[PSC_ST_KILL_BIT] <= hot_swap_kill_n;
          rdata_q[PSC_ST_REMOTE_BIT] <= remote_on_n;
          rdata_q[PSC_ST_MAIN_BIT] <= main_en_q;
          rdata_q[PSC_ST_PG_BIT] <= pg_q;
          rdata_q[PSC_ST_ALERT_BIT] <= ~fault_alert_n;
          rdata_q[PSC_ST_ADDR_LSB +: 3] <= addr_q;
        end
        PSC_FAULT_OFS: begin
          rdata_q[PSC_FLT_W-1:0] <= flags_q;
        end
        PSC_MASK_OFS: begin
          rdata_q[PSC_FLT_W-1:0] <= mask_q;
        end
        default: begin
          rresp_q <= PSC_RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // sticky fault flags and alert
  psc_fault_flags u_flags (
    .core_clk(core_clk),
    .rstn(rstn),
    .fault_evt(fault_evt),
    .fault_mask(mask_q),
    .clr_we(clr_we),
    .clr_bits(wr_data[PSC_FLT_W-1:0]),
    .flags_q(flags_q),
    .fault_alert_n(fault_alert_n)
  );

  // address straps
  // straps are caught once on the first edge after reset release; an open
  // pin reads high through its pull-up, a shorted pin reads low
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      strap_taken_q <= 1'b0;
      addr_q <= PSC_ADDR_RST;
    end else if (!strap_taken_q) begin
      strap_taken_q <= 1'b1;
      addr_q <= {addr_strap_2, addr_strap_1, addr_strap_0};
    end
  end

  assign target_addr = addr_q;

  // main output enable
  // either pin high is a disable request; software can also hold it off
  assign on_req = !hot_swap_kill_n && !remote_on_n && ctrl_en_q;

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      main_en_q <= 1'b0;
    end else begin
      main_en_q <= on_req;
    end
  end

  assign main_enable = main_en_q;

  // power good
  // the off path uses the pin directly, one cycle, far inside the 2 ms limit
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      pg_q <= 1'b0;
    end else begin
      pg_q <= on_req && main_en_q && outputs_valid && ~|flags_q;
    end
  end

  assign power_good = pg_q;

  // presence and serial lines
  // the module grounds its presence contact; the host does the sensing
  assign present_n = 1'b0;
  // open drain: the pins are only ever pulled low, never driven high
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign scl_oe = mgmt_scl_low;
  assign sda_oe = mgmt_sda_low;
  assign mgmt_scl = scl_i;
  assign mgmt_sda = sda_i;

  // checks
  logic [31:0] off_cnt_q;

  // cycles since remote on was released while power good stayed high
  always_ff @(posedge core_clk) begin
    if (!rstn || !remote_on_n || !pg_q) begin
      off_cnt_q <= '0;
    end else begin
      off_cnt_q <= off_cnt_q + 32'h1;
    end
  end

  a_pg_off_bound: assert property (@(posedge core_clk) disable iff (!rstn)
    off_cnt_q < PG_OFF_CYCLES)
    else $error("power good held too long after remote off");
  a_pg_needs_good: assert property (@(posedge core_clk) disable iff (!rstn)
    power_good |-> $past(outputs_valid) && main_enable && ($past(flags_q) == '0))
    else $error("power good without valid outputs or with fault");
  a_main_needs_pins: assert property (@(posedge core_clk) disable iff (!rstn)
    main_enable |-> $past(!hot_swap_kill_n) && $past(!remote_on_n))
    else $error("main enabled while a disable pin is high");
  a_kill_drops_main: assert property (@(posedge core_clk) disable iff (!rstn)
    hot_swap_kill_n |=> !main_enable)
    else $error("main still enabled after kill released");
  a_remote_turns_on: assert property (@(posedge core_clk) disable iff (!rstn)
    !hot_swap_kill_n && !remote_on_n && ctrl_en_q |=> main_enable)
    else $error("main not enabled with both pins low");
  a_strap_order: assert property (@(posedge core_clk) disable iff (!rstn)
    !strap_taken_q |=> target_addr == $past({addr_strap_2, addr_strap_1, addr_strap_0}))
    else $error("strap address wrong");
  a_sda_open_drain: assert property (@(posedge core_clk) disable iff (!rstn)
    sda_oe |-> !sda_o)
    else $error("data line driven high");
  a_alert_level: assert property (@(posedge core_clk) disable iff (!rstn)
    ((flags_q & mask_q) != '0) && $stable(mask_q) |-> !fault_alert_n)
    else $error("alert high while fault flagged");
  a_bresp_hold: assert property (@(posedge core_clk) disable iff (!rstn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");

  c_power_good: cover property (@(posedge core_clk) disable iff (!rstn) $rose(power_good));
  c_alert: cover property (@(posedge core_clk) disable iff (!rstn) $fell(fault_alert_n));
  c_remote_off: cover property (@(posedge core_clk) disable iff (!rstn) power_good ##1 remote_on_n);
  c_clear: cover property (@(posedge core_clk) disable iff (!rstn) clr_we && |fault_evt);
endmodule

// ### core/psc_pkg.sv
package psc_pkg;
  // clock rate and timing
  localparam int unsigned PSC_CLK_KHZ = 250000;
  localparam int unsigned PSC_PG_OFF_MS = 2;
  // longest time rounds down to whole cycles
  localparam int unsigned PSC_PG_OFF_CYCLES = PSC_PG_OFF_MS * PSC_CLK_KHZ;

  // widths
  localparam int unsigned PSC_FLT_W = 8;
  localparam int unsigned PSC_ADDR_W = 4;

  // register byte offsets
  localparam logic [PSC_ADDR_W-1:0] PSC_CTRL_OFS = 4'h0;
  localparam logic [PSC_ADDR_W-1:0] PSC_STATUS_OFS = 4'h4;
  localparam logic [PSC_ADDR_W-1:0] PSC_FAULT_OFS = 4'h8;
  localparam logic [PSC_ADDR_W-1:0] PSC_MASK_OFS = 4'hc;

  // field positions in the status word
  localparam int unsigned PSC_ST_KILL_BIT = 0;
  localparam int unsigned PSC_ST_REMOTE_BIT = 1;
  localparam int unsigned PSC_ST_MAIN_BIT = 2;
  localparam int unsigned PSC_ST_PG_BIT = 3;
  localparam int unsigned PSC_ST_ALERT_BIT = 4;
  localparam int unsigned PSC_ST_ADDR_LSB = 8;

  // values after reset
  localparam logic PSC_CTRL_RST = 1'b1;
  localparam logic [PSC_FLT_W-1:0] PSC_MASK_RST = 8'hff;
  localparam logic [2:0] PSC_ADDR_RST = 3'h7;

  // axi responses
  localparam logic [1:0] PSC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PSC_RESP_SLVERR = 2'h2;
endpackage

// ### testbench/psc_host_model.sv
`timescale 1ns/1ps
// host side of the slot: kill contact, remote on, straps and the shared open-drain lines
module psc_host_model (
  input wire logic seated,
  input wire logic on_req,
  input wire logic [2:0] strap_short_n,
  input wire logic scl_oe,
  input wire logic sda_oe,
  input wire logic host_scl_low,
  input wire logic host_sda_low,
  input wire logic present_n,
  output logic hot_swap_kill_n,
  output logic remote_on_n,
  output logic [2:0] straps,
  output logic scl_i,
  output logic sda_i,
  output logic installed
);
  // kill contact goes to return only when fully seated, else the pull-up wins
  assign hot_swap_kill_n = !seated;
  assign remote_on_n = !on_req;
  // open strap reads high through the pull-up, a short reads low
  assign straps = strap_short_n;
  // wired-and lines: any party pulling low wins, pull-up otherwise
  assign scl_i = !(scl_oe || host_scl_low);
  assign sda_i = !(sda_oe || host_sda_low);
  // presence pin is the host's only sign of a module in the slot
  assign installed = (present_n === 1'b0);
endmodule

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import psc_pkg::*;
  logic core_clk = 0, rstn = 0;
  logic [3:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp;
  logic seated = 0, on_req = 0, outputs_valid = 0, hs = 0, hd = 0, ms = 0, md = 0;
  logic [2:0] strap = 0, straps, target_addr;
  logic [7:0] fault_evt = 0;
  logic kill_n, ron_n, main_enable, power_good, fault_alert_n, present_n, installed;
  logic scl_i, sda_i, scl_o, sda_o, scl_oe, sda_oe, mgmt_scl, mgmt_sda;
  int miscompares = 0, tests_run = 0;
  always #2 core_clk = ~core_clk;
  // short power good bound keeps the assertion window small
  psc_pins #(.PG_OFF_CYCLES(8)) u_dut (.core_clk(core_clk), .rstn(rstn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hot_swap_kill_n(kill_n), .remote_on_n(ron_n), .addr_strap_2(straps[2]), .addr_strap_1(straps[1]),
    .addr_strap_0(straps[0]), .outputs_valid(outputs_valid), .fault_evt(fault_evt),
    .main_enable(main_enable), .power_good(power_good), .fault_alert_n(fault_alert_n),
    .present_n(present_n), .target_addr(target_addr), .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe), .mgmt_scl_low(ms), .mgmt_sda_low(md),
    .mgmt_scl(mgmt_scl), .mgmt_sda(mgmt_sda));
  psc_host_model u_host (.seated(seated), .on_req(on_req), .strap_short_n(strap), .scl_oe(scl_oe),
    .sda_oe(sda_oe), .host_scl_low(hs), .host_sda_low(hd), .present_n(present_n),
    .hot_swap_kill_n(kill_n), .remote_on_n(ron_n), .straps(straps), .scl_i(scl_i), .sda_i(sda_i),
    .installed(installed));
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // hang guard: a bound used up is a mismatch
  task automatic hang();
    miscompares++;
    print_verdict();
  endtask
  task automatic wt(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (bvalid) break;
    end
    if (n == 50) hang();
    bready <= 0;
    check(bresp, er);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    @(posedge core_clk);
    araddr <= a; arvalid <= 1; rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 0;
      if (rvalid) break;
    end
    if (n == 50) hang();
    rready <= 0;
    check(rdata, ed);
    check(rresp, er);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic do_reset(input logic [2:0] s);
    @(posedge core_clk);
    strap <= s; rstn <= 0;
    repeat (16) @(posedge core_clk);
    rstn <= 1;
    cyc(3);
  endtask
  initial begin
    logic [1:0] c;
    // straps latched at reset release, strap 2 most significant
    foreach (c[i]) begin
      do_reset(i ? 3'h6 : 3'h1);
      check(target_addr, i ? 3'h6 : 3'h1);
    end
    rd(PSC_STATUS_OFS, 32'h0000_0103, PSC_RESP_OKAY);
    rd(PSC_CTRL_OFS, 32'h1, PSC_RESP_OKAY);
    rd(PSC_MASK_OFS, 32'hff, PSC_RESP_OKAY);
    rd(4'h2, 32'h0, PSC_RESP_SLVERR);
    wt(4'h2, 32'h0, PSC_RESP_SLVERR);
    wt(PSC_STATUS_OFS, 32'hff, PSC_RESP_OKAY);
    check(present_n, 1'b0);
    check(installed, 1'b1);
    $display("registers done");
    // every kill and remote combination; pg rises two cycles after the request
    outputs_valid <= 1;
    for (int i = 0; i < 4; i++) begin
      c = 2'(i);
      @(posedge core_clk);
      seated <= !c[0]; on_req <= !c[1];
      cyc(2);
      check(main_enable, c == 0);
      check(power_good, c == 0);
    end
    @(posedge core_clk);
    seated <= 1; on_req <= 1; outputs_valid <= 0;
    cyc(3);
    check(power_good, 1'b0);
    @(posedge core_clk);
    outputs_valid <= 1;
    cyc(3);
    check(power_good, 1'b1);
    $display("enables done");
    // fault flag and alert move together; masked flag raises no alert
    @(posedge core_clk);
    fault_evt <= 8'h04;
    cyc(1);
    check(fault_alert_n, 1'b0);
    @(posedge core_clk);
    fault_evt <= 8'h00;
    cyc(1);
    check(power_good, 1'b0);
    rd(PSC_FAULT_OFS, 32'h04, PSC_RESP_OKAY);
    wt(PSC_FAULT_OFS, 32'h04, PSC_RESP_OKAY);
    cyc(1);
    check(fault_alert_n, 1'b1);
    wt(PSC_MASK_OFS, 32'hfb, PSC_RESP_OKAY);
    @(posedge core_clk);
    fault_evt <= 8'h04;
    cyc(1);
    @(posedge core_clk);
    fault_evt <= 8'h00;
    cyc(2);
    check(fault_alert_n, 1'b1);
    // event lands on the very edge that executes the clear: the event wins
    fork
      wt(PSC_FAULT_OFS, 32'hff, PSC_RESP_OKAY);
      begin
        @(posedge core_clk);
        fault_evt <= 8'h01;
        @(posedge core_clk);
        fault_evt <= 8'h00;
      end
    join
    rd(PSC_FAULT_OFS, 32'h01, PSC_RESP_OKAY);
    wt(PSC_FAULT_OFS, 32'hff, PSC_RESP_OKAY);
    wt(PSC_CTRL_OFS, 32'h0, PSC_RESP_OKAY);
    cyc(2);
    check(main_enable, 1'b0);
    $display("faults done");
    // open-drain lines: engine pull shows on the enable, host pull on the sampled level
    @(posedge core_clk);
    ms <= 1; hd <= 1;
    cyc(1);
    check({scl_oe, sda_oe, scl_o, mgmt_scl, mgmt_sda}, 5'b10000);
    @(posedge core_clk);
    ms <= 0; hd <= 0; md <= 1;
    cyc(1);
    check({scl_oe, sda_oe, sda_o, mgmt_scl, mgmt_sda}, 5'b01010);
    $display("lines done");
    print_verdict();
  end
endmodule
